// ==== hdl/slot_buffer.sv ====
// two-entry skid buffer: output stage plus one spare entry
`timescale 1ns/100ps
module slot_buffer #(
    parameter int W = 8
) (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    stream_if.snk up,
    output logic [W-1:0] out_data_o,
    output logic out_valid_o,
    input wire logic out_ready_i
);

    logic [W-1:0] out_data_reg;
    logic out_valid_reg;
    logic [W-1:0] skid_data_reg;
    logic skid_valid_reg;
    logic up_ready_reg;
    logic out_move;
    logic in_take;

    // ------------------------------------------------------------
    // handshake terms
    // ------------------------------------------------------------
    // ready is its own flop, the inverse of the spare entry's valid, so the
    // producer sees neither a comb path from out_ready_i nor an inverter
    assign up.ready = up_ready_reg;
    assign out_move = out_ready_i | ~out_valid_reg;
    assign in_take = up.valid & up_ready_reg;
    assign out_data_o = out_data_reg;
    assign out_valid_o = out_valid_reg;

    // output stage: refilled from the spare entry first to keep order
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            out_valid_reg <= 1'b0;
            out_data_reg <= '0;
        end else if (ce_i && out_move) begin
            if (skid_valid_reg) begin
                out_valid_reg <= 1'b1;
                out_data_reg <= skid_data_reg;
            end else begin
                out_valid_reg <= in_take;
                if (in_take) begin
                    out_data_reg <= up.data;
                end
            end
        end
    end

    // spare entry: catches the word that arrives while the receiver stalls
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            skid_valid_reg <= 1'b0;
            up_ready_reg <= 1'b1;
            skid_data_reg <= '0;
        end else if (ce_i) begin
            if (out_move) begin
                skid_valid_reg <= 1'b0;
                up_ready_reg <= 1'b1;
            end else if (in_take) begin
                skid_valid_reg <= 1'b1;
                up_ready_reg <= 1'b0;
                skid_data_reg <= up.data;
            end
        end
    end

endmodule // slot_buffer

// ==== hdl/stream_if.sv ====
// valid/ready stream carrier between the mapper and its output buffer
`timescale 1ns/100ps
interface stream_if #(
    parameter int W = 8
);
    logic [W-1:0] data;
    logic valid;
    logic ready;

    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface

// ==== hdl/vc_map_pkg.sv ====
// constants shared by the virtual converter mapper, its property checks and its bench
package vc_map_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 16;
    localparam logic [ADDR_W-1:0] APP_MODE_ADDR = 16'h0200;
    localparam logic [ADDR_W-1:0] DEC_RATIO_ADDR = 16'h0201;
    localparam int REG_W = 8;

    // ------------------------------------------------------------
    // field layout
    // ------------------------------------------------------------
    localparam int MODE_LSB = 0;
    localparam int MODE_W = 4;
    localparam int QIGN_BIT = 5;
    localparam int DEC_LSB = 0;
    localparam int DEC_W = 4;

    // ------------------------------------------------------------
    // mode codes and reset values
    // ------------------------------------------------------------
    localparam logic [MODE_W-1:0] MODE_FULL = 4'h0;
    localparam logic [MODE_W-1:0] MODE_DDC1 = 4'h1;
    localparam logic [MODE_W-1:0] MODE_DDC2 = 4'h2;
    localparam logic [MODE_W-1:0] MODE_DDC4 = 4'h3;
    localparam logic [MODE_W-1:0] MODE_RESET = 4'h0;
    localparam logic QIGN_RESET = 1'b0;
    localparam logic [DEC_W-1:0] DEC_RESET = 4'h1;

    // ------------------------------------------------------------
    // slot geometry
    // ------------------------------------------------------------
    localparam int NUM_SLOTS = 8;
    localparam int NUM_DDC = 4;
    localparam logic [NUM_SLOTS-1:0] FULL_MASK = 8'h03;

endpackage

// ==== hdl/virtual_converter_mapper.sv ====
// application mode select and virtual converter slot mapping for the transport layer
// Functional notes
// - mode field bits 3:0 select full bandwidth, one, two or four downconverters.
// - bit 5 set gives real output, clear gives complex I/Q output.
// - decimation field bits 3:0; output rate is input rate over that ratio.
// - every real, I or Q stream travels as its own virtual converter.
// - at most eight slots, 0 to 7; usage depends on mode and type.
// - each channel yields I and Q when complex, only I when real.
// - complex output puts channel n I in slot 2n, Q in 2n+1.
// - real downconversion output puts channel n I in slot n.
// - full bandwidth: core A to slot 0, core B to slot 1, rest unused.
// - downconversion modes offer one, two or four channels through the mode field.
// - slot counts: full 2; one 1/2; two 2/4; four 4/8.
// - same count and I/Q pairing for digital or analog quadrature sources.
`timescale 1ns/100ps
module virtual_converter_mapper
    import vc_map_pkg::*;
#(
    parameter int SAMPLE_W = 16
) (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic [REG_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [REG_W-1:0] reg_rdata_o,
    input wire logic [SAMPLE_W-1:0] core_a_i,
    input wire logic [SAMPLE_W-1:0] core_b_i,
    input wire logic [NUM_DDC*SAMPLE_W-1:0] ddc_i_i,
    input wire logic [NUM_DDC*SAMPLE_W-1:0] ddc_q_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    output logic [NUM_SLOTS*SAMPLE_W-1:0] slot_data_o,
    output logic [NUM_SLOTS-1:0] slot_active_o,
    output logic slot_valid_o,
    input wire logic slot_ready_i,
    output logic [3:0] vc_count_o
);

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    localparam int SLOT_DW = NUM_SLOTS * SAMPLE_W;
    localparam int PAY_W = SLOT_DW + NUM_SLOTS;

    // counts are hard-sized at 4 bits and channels at 3 bits,
    // so the package geometry is held to what those widths can serve
    generate
        if (SAMPLE_W < 1 || SAMPLE_W > 64) begin : g_bad_width
            $error("sample width must lie between 1 and 64");
        end
        if (NUM_SLOTS != 2 * NUM_DDC || NUM_SLOTS > 8) begin : g_bad_slots
            $error("slot count must be twice the channel count and at most eight");
        end
        if (MODE_LSB + MODE_W > REG_W || QIGN_BIT >= REG_W) begin : g_bad_mode_field
            $error("mode register fields must fit the register width");
        end
        if (DEC_LSB + DEC_W > REG_W || DEC_RESET == '0) begin : g_bad_dec_field
            $error("ratio field must fit the register and reset to a nonzero ratio");
        end
    endgenerate

    // ------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------
    // number of downconversion channels a mode code asks for; 0 otherwise
    function automatic logic [2:0] chan_count(input logic [MODE_W-1:0] mode);
        logic [2:0] n;
        n = 3'h0;
        case (mode)
            MODE_DDC1: n = 3'h1;
            MODE_DDC2: n = 3'h2;
            MODE_DDC4: n = 3'h4;
            default: n = 3'h0;
        endcase
        return n;
    endfunction

    // virtual converters in use for a mode and output type;
    // full bandwidth counts both cores whatever the output type bit says
    function automatic logic [3:0] slot_count(input logic [MODE_W-1:0] mode, input logic real_out);
        logic [3:0] c;
        c = 4'h0;
        if (mode == MODE_FULL) begin
            c = 4'h2; // both cores always presented
        end else if (real_out) begin
            c = {1'b0, chan_count(mode)};
        end else begin
            c = {chan_count(mode), 1'b0};
        end
        return c;
    endfunction

    // unused slots stay zero so the transport side never sees stale samples
    // place each stream in its slot and build the matching active mask
    function automatic logic [PAY_W-1:0] map_slots(
        input logic [MODE_W-1:0] mode,
        input logic real_out,
        input logic [SAMPLE_W-1:0] a,
        input logic [SAMPLE_W-1:0] b,
        input logic [NUM_DDC*SAMPLE_W-1:0] di,
        input logic [NUM_DDC*SAMPLE_W-1:0] dq
    );
        logic [SLOT_DW-1:0] d;
        logic [NUM_SLOTS-1:0] m;
        logic [2:0] nch;
        d = '0;
        m = '0;
        nch = chan_count(mode);
        if (mode == MODE_FULL) begin
            d[0 +: SAMPLE_W] = a;
            d[SAMPLE_W +: SAMPLE_W] = b;
            m = FULL_MASK;
        end else begin
            for (int n = 0; n < NUM_DDC; n++) begin
                if (n < int'(nch)) begin
                    if (real_out) begin
                        d[n*SAMPLE_W +: SAMPLE_W] = di[n*SAMPLE_W +: SAMPLE_W];
                        m[n] = 1'b1;
                    end else begin
                        d[2*n*SAMPLE_W +: SAMPLE_W] = di[n*SAMPLE_W +: SAMPLE_W];
                        d[(2*n+1)*SAMPLE_W +: SAMPLE_W] = dq[n*SAMPLE_W +: SAMPLE_W];
                        m[2*n] = 1'b1;
                        m[2*n+1] = 1'b1;
                    end
                end
            end
        end
        return {m, d}; // one stream per slot
    endfunction

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    // configuration state; writes land at the strobe edge, reads answer one
    // cycle later, and a read beside a write in one cycle sees the old value
    logic [MODE_W-1:0] mode_reg;
    logic qign_reg;
    logic [DEC_W-1:0] dec_reg;
    logic [REG_W-1:0] rdata_reg;
    logic [3:0] vc_count_reg;
    logic cfg_changed_reg;

    wire wr_mode = reg_wr_i & (reg_addr_i == APP_MODE_ADDR);
    wire wr_dec = reg_wr_i & (reg_addr_i == DEC_RATIO_ADDR);
    wire rd_mode = reg_rd_i & (reg_addr_i == APP_MODE_ADDR);
    wire rd_dec = reg_rd_i & (reg_addr_i == DEC_RATIO_ADDR);

    // any configuration write, used to restart the decimation phase
    wire wr_any = wr_mode | wr_dec;

    // readback images built from the field positions; reserved bits read as zero
    logic [REG_W-1:0] mode_image;
    logic [REG_W-1:0] dec_image;
    always_comb begin
        mode_image = '0;
        mode_image[MODE_LSB +: MODE_W] = mode_reg;
        mode_image[QIGN_BIT] = qign_reg;
    end
    always_comb begin
        dec_image = '0;
        dec_image[DEC_LSB +: DEC_W] = dec_reg;
    end

    // one read mux; an unmapped address selects zero
    wire [REG_W-1:0] rd_image = rd_mode ? mode_image : (rd_dec ? dec_image : '0);

    // mode field and output type stored on a write to the mode register
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            mode_reg <= MODE_RESET;
            qign_reg <= QIGN_RESET;
        end else if (ce_i && wr_mode) begin
            mode_reg <= reg_wdata_i[MODE_LSB +: MODE_W];
            qign_reg <= reg_wdata_i[QIGN_BIT];
        end
    end

    // decimation ratio stored on a write to its register
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            dec_reg <= DEC_RESET;
        end else if (ce_i && wr_dec) begin
            dec_reg <= reg_wdata_i[DEC_LSB +: DEC_W];
        end
    end

    // read data registered one cycle after the strobe; unmapped reads give zero
    // it holds until the next read strobe
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            rdata_reg <= '0;
        end else if (ce_i && reg_rd_i) begin
            rdata_reg <= rd_image;
        end
    end

    // converter count follows the configuration, one cycle behind it
    // a count of zero flags an undefined mode code
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            vc_count_reg <= slot_count(MODE_RESET, QIGN_RESET);
        end else if (ce_i) begin
            vc_count_reg <= slot_count(mode_reg, qign_reg);
        end
    end

    // a config write restarts the decimation phase in the cycle after it, sample or not
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            cfg_changed_reg <= 1'b0;
        end else if (ce_i) begin
            cfg_changed_reg <= wr_any;
        end
    end

    // ------------------------------------------------------------
    // decimation
    // ------------------------------------------------------------
    // every sample taken advances the phase, forwarded or not, bar one taken in the cycle after a config write; only the
    // take at which the phase reaches ratio-1 hands a word on, so one word
    // leaves per ratio samples taken. a refused sample is not taken and
    // does not count, so a stall never shifts the decimation phase.
    // a ratio of zero is served as one, so the stream never stops outright
    logic [DEC_W-1:0] phase_reg;
    wire [DEC_W-1:0] dec_eff = (dec_reg == '0) ? DEC_RESET : dec_reg;
    wire [DEC_W-1:0] dec_last = dec_eff - DEC_RESET;
    wire in_take = in_valid_i & in_ready_o;
    wire phase_hit = (phase_reg == dec_last);

    // mode decode: a code outside the table maps no slot and forwards nothing
    wire mode_full = (mode_reg == MODE_FULL);
    wire [2:0] mode_chans = chan_count(mode_reg);
    wire mode_ok = mode_full || (mode_chans != 3'h0);

    // a word goes on only at a phase hit in a defined mode, never on the
    // sample taken in the cycle right after a configuration write, whose phase is stale
    wire fwd_hit = phase_hit & mode_ok & ~cfg_changed_reg;

    // input phase counter: one sample in dec_eff goes out
    // a config write restarts the count from zero
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            phase_reg <= '0;
        end else if (ce_i) begin
            if (cfg_changed_reg) begin
                phase_reg <= '0;
            end else if (in_take) begin
                phase_reg <= phase_hit ? '0 : phase_reg + DEC_RESET;
            end
        end
    end

    // ------------------------------------------------------------
    // slot mapping into the output buffer
    // ------------------------------------------------------------
    // digital and analog I/Q sources arrive on the same ddc ports, so the
    // slot pairing below is the same for both
    wire [PAY_W-1:0] mapped = map_slots(mode_reg, qign_reg, core_a_i, core_b_i, ddc_i_i, ddc_q_i);
    wire [PAY_W-1:0] buf_out;
    logic buf_valid;

    // carrier between the mapper and its two-entry buffer
    stream_if #(.W(PAY_W)) map_stream ();

    // only a decimation hit in a defined mode reaches the transport side;
    // undefined mode codes map no slot at all
    assign map_stream.data = mapped;
    assign map_stream.valid = in_valid_i & fwd_hit;
    // back-pressure reaches the source even for samples that are decimated away
    assign in_ready_o = map_stream.ready;

    // the buffer parks words across a receiver stall so none is lost
    slot_buffer #(
        .W(PAY_W)
    ) slot_buffer_inst (
        .clock_i(clock_i),
        .sys_rst_i(sys_rst_i),
        .ce_i(ce_i),
        .up(map_stream),
        .out_data_o(buf_out),
        .out_valid_o(buf_valid),
        .out_ready_i(slot_ready_i)
    );

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // all come from flops: buffer output stage, read data, count register.
    // a forwarded sample shows on the slots straight after its taking edge
    // when the buffer is empty; a stalled receiver parks one word in the
    // output stage and one in the spare entry, and only then is the source
    // refused. the count trails a mode write by one cycle, so it may not
    // match the slots of words still waiting in the buffer.
    assign slot_data_o = buf_out[SLOT_DW-1:0];
    assign slot_active_o = buf_out[PAY_W-1:SLOT_DW];
    assign slot_valid_o = buf_valid;
    assign reg_rdata_o = rdata_reg;
    assign vc_count_o = vc_count_reg;

endmodule // virtual_converter_mapper

// ==== sim/transport_sink.sv ====
// transport layer stand-in: accepts mapped words promptly, slowly or not at all
`timescale 1ns/100ps
module transport_sink (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic hold_i,
    input wire logic slow_i,
    output logic ready_o
);
    int seed = 32'haee3e6bc;
    // ready moves only after an edge; random gaps exercise the skid entry
    always @(posedge clock_i) begin
        if (sys_rst_i || hold_i) ready_o <= 1'b0;
        else if (slow_i) ready_o <= 1'($random(seed) & 1);
        else ready_o <= 1'b1;
    end
endmodule // transport_sink

// ==== sim/vc_map_properties.sv ====
// concurrent checks on the virtual converter mapper ports
`timescale 1ns/100ps
module vc_map_properties
    import vc_map_pkg::*;
#(
    parameter int SAMPLE_W = 16
) (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic [REG_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [REG_W-1:0] reg_rdata_o,
    input wire logic [NUM_SLOTS*SAMPLE_W-1:0] slot_data_o,
    input wire logic [NUM_SLOTS-1:0] slot_active_o,
    input wire logic slot_valid_o,
    input wire logic slot_ready_i,
    input wire logic [3:0] vc_count_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);
    // ---------
    // helpers
    // ---------
    // every slot not flagged active must read as zero
    logic idle_zero;
    always_comb begin
        idle_zero = 1'b1;
        for (int k = 0; k < NUM_SLOTS; k++) begin
            if (!slot_active_o[k] && slot_data_o[k*SAMPLE_W +: SAMPLE_W] != '0) idle_zero = 1'b0;
        end
    end
    // converter count implied by a mode register value
    function automatic logic [3:0] vc_of(logic [REG_W-1:0] v);
        logic [3:0] n;
        n = (v[3:0] == MODE_DDC1) ? 4'h1 : (v[3:0] == MODE_DDC2) ? 4'h2 : (v[3:0] == MODE_DDC4) ? 4'h4 : 4'h0;
        if (v[3:0] == MODE_FULL) return 4'h2;
        return v[QIGN_BIT] ? n : n << 1;
    endfunction
    sequence mode_wr_s;
        ce_i && reg_wr_i && reg_addr_i == APP_MODE_ADDR;
    endsequence
    sequence no_mode_wr_s;
        ce_i && !(reg_wr_i && reg_addr_i == APP_MODE_ADDR);
    endsequence
    // ---------
    // properties
    // ---------
    a_mode_count: assert property (mode_wr_s ##1 no_mode_wr_s |=>
        vc_count_o == vc_of($past(reg_wdata_i, 2))) else $error("converter count wrong after mode write");
    a_mode_readback: assert property (mode_wr_s ##1 no_mode_wr_s ##1
        (ce_i && reg_rd_i && reg_addr_i == APP_MODE_ADDR) |=> reg_rdata_o == ($past(reg_wdata_i, 3) & 8'h2f))
        else $error("mode register readback wrong");
    a_mode_rsvd: assert property (ce_i && reg_rd_i && reg_addr_i == APP_MODE_ADDR |=>
        reg_rdata_o[7:6] == 2'b00 && !reg_rdata_o[4]) else $error("mode reserved bits not zero");
    a_dec_rsvd: assert property (ce_i && reg_rd_i && reg_addr_i == DEC_RATIO_ADDR |=>
        reg_rdata_o[7:4] == 4'h0) else $error("ratio reserved bits not zero");
    a_unmapped_zero: assert property (ce_i && reg_rd_i && reg_addr_i != APP_MODE_ADDR &&
        reg_addr_i != DEC_RATIO_ADDR |=> reg_rdata_o == 8'h00) else $error("unmapped read not zero");
    a_slot_hold: assert property (slot_valid_o && !slot_ready_i |=>
        slot_valid_o && $stable(slot_data_o) && $stable(slot_active_o)) else $error("word changed while stalled");
    a_unused_zero: assert property (slot_valid_o |-> idle_zero) else $error("unused slot carries data");
    a_active_shape: assert property (slot_valid_o |->
        slot_active_o inside {8'h01, 8'h03, 8'h0f, 8'hff}) else $error("active slot set not contiguous");
    a_release_idle: assert property ($fell(sys_rst_i) |->
        !slot_valid_o && slot_active_o == 8'h00 && vc_count_o == 4'h2) else $error("state after reset wrong");
endmodule // vc_map_properties

// ==== sim/virtual_converter_mapper_bench.sv ====
// self-checking bench for the virtual converter mapper
`timescale 1ns/100ps
module virtual_converter_mapper_bench;
    import vc_map_pkg::*;
    localparam int W = 16;
    localparam int SW = NUM_SLOTS*W;
    logic clock_i, sys_rst_i, ce_i, reg_wr_i, reg_rd_i, in_valid_i, in_ready_o, hold, slow;
    logic slot_valid_o, slot_ready_i;
    logic [ADDR_W-1:0] reg_addr_i;
    logic [REG_W-1:0] reg_wdata_i, reg_rdata_o, v;
    logic [W-1:0] core_a_i, core_b_i;
    logic [NUM_DDC*W-1:0] ddc_i_i, ddc_q_i;
    logic [SW-1:0] slot_data_o;
    logic [NUM_SLOTS-1:0] slot_active_o;
    logic [3:0] vc_count_o, cur_mode;
    logic cur_real;
    int n_fail, checked, seed;
    int rl[4] = '{2, 3, 0, 15};
    logic [SW+NUM_SLOTS-1:0] exp_q[$];
    virtual_converter_mapper #(.SAMPLE_W(W)) virtual_converter_mapper_inst (.clock_i(clock_i),
        .sys_rst_i(sys_rst_i), .ce_i(ce_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .core_a_i(core_a_i),
        .core_b_i(core_b_i), .ddc_i_i(ddc_i_i), .ddc_q_i(ddc_q_i), .in_valid_i(in_valid_i),
        .in_ready_o(in_ready_o), .slot_data_o(slot_data_o), .slot_active_o(slot_active_o),
        .slot_valid_o(slot_valid_o), .slot_ready_i(slot_ready_i), .vc_count_o(vc_count_o));
    transport_sink transport_sink_inst (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .hold_i(hold),
        .slow_i(slow), .ready_o(slot_ready_i));
    // ---------
    // clock and checking helpers
    // ---------
    initial begin
        clock_i = 1'b0;
        forever #10 clock_i = ~clock_i;
    end
    task automatic chk(string what, logic [SW+NUM_SLOTS-1:0] e, logic [SW+NUM_SLOTS-1:0] s);
        checked++;
        if (e !== s) begin
            n_fail++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, e, s);
        end
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // register strobes last exactly one cycle
    task automatic wr(logic [ADDR_W-1:0] a, logic [REG_W-1:0] d);
        @(negedge clock_i);
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_wr_i = 1'b1;
        @(negedge clock_i);
        reg_wr_i = 1'b0;
    endtask
    task automatic rd(logic [ADDR_W-1:0] a, logic [REG_W-1:0] e);
        @(negedge clock_i);
        reg_addr_i = a;
        reg_rd_i = 1'b1;
        @(negedge clock_i);
        reg_rd_i = 1'b0;
        chk("register read", e, reg_rdata_o);
    endtask
    // expected slot word {data, active} for the current inputs
    function automatic logic [SW+NUM_SLOTS-1:0] map_of(logic [3:0] m, logic r);
        logic [SW-1:0] d;
        int n;
        d = '0;
        n = (m == MODE_DDC4) ? 4 : (m > MODE_DDC4) ? 0 : int'(m);
        if (m == MODE_FULL) return {{(SW-2*W){1'b0}}, core_b_i, core_a_i, 8'h03};
        for (int k = 0; k < n; k++) begin
            d[(r ? k : 2*k)*W +: W] = ddc_i_i[k*W +: W];
            if (!r) d[(2*k+1)*W +: W] = ddc_q_i[k*W +: W];
        end
        return {d, NUM_SLOTS'((1 << (r ? n : 2*n)) - 1)};
    endfunction
    task automatic cfg(logic [3:0] m, logic r, logic [3:0] q);
        logic [SW+NUM_SLOTS-1:0] e;
        cur_mode = m;
        cur_real = r;
        e = map_of(m, r);
        wr(APP_MODE_ADDR, {2'b00, r, 1'b0, m});
        wr(DEC_RATIO_ADDR, {4'h0, q});
        chk("converter count", $countones(e[NUM_SLOTS-1:0]), vc_count_o);
    endtask
    // offer samples every cycle; ready seen at the falling edge holds to the taking edge
    task automatic send(int n, int q);
        int taken;
        taken = 0;
        while (taken < n) begin
            @(negedge clock_i);
            core_a_i = W'($random(seed));
            core_b_i = W'($random(seed));
            ddc_i_i = {$random(seed), $random(seed)};
            ddc_q_i = {$random(seed), $random(seed)};
            in_valid_i = 1'b1;
            if (in_ready_o) taken++;
            if (in_ready_o && taken % q == 0 && cur_mode <= MODE_DDC4) exp_q.push_back(map_of(cur_mode, cur_real));
        end
        @(negedge clock_i);
        in_valid_i = 1'b0;
    endtask
    task automatic drain();
        for (int i = 0; i < 200 && exp_q.size() > 0; i++) @(negedge clock_i);
        chk("words outstanding", 0, exp_q.size());
    endtask
    // compare every word the receiver takes, in order
    always @(posedge clock_i) begin
        if (!sys_rst_i && ce_i && slot_valid_o && slot_ready_i) begin
            if (exp_q.size() == 0) chk("surplus word", 0, 1);
            else chk("slot word", exp_q.pop_front(), {slot_data_o, slot_active_o});
        end
    end
    // ---------
    // tests
    // ---------
    initial begin
        {reg_wr_i, reg_rd_i, in_valid_i, hold, slow, core_a_i, core_b_i, ddc_i_i, ddc_q_i} = '0;
        {reg_addr_i, reg_wdata_i, n_fail, checked} = '0;
        {ce_i, sys_rst_i} = 2'b11;
        seed = 32'haee3e6bc;
        repeat (5) @(negedge clock_i);
        sys_rst_i = 1'b0;
        rd(APP_MODE_ADDR, 8'h00);
        rd(DEC_RATIO_ADDR, 8'h01);
        $display("test done: reset values");
        for (int i = 0; i < 4; i++) begin
            v = REG_W'($random(seed));
            wr(APP_MODE_ADDR, v);
            rd(APP_MODE_ADDR, v & 8'h2f);
            wr(DEC_RATIO_ADDR, v);
            rd(DEC_RATIO_ADDR, v & 8'h0f);
        end
        rd(16'h0202, 8'h00);
        ce_i = 1'b0; // a frozen clock enable must swallow the write
        wr(DEC_RATIO_ADDR, 8'h0e);
        ce_i = 1'b1;
        rd(DEC_RATIO_ADDR, v & 8'h0f);
        $display("test done: registers");
        for (int m = 0; m < 5; m++) for (int r = 0; r < 2; r++) begin
            cfg(4'(m), 1'(r), 4'h1);
            send(3, 1);
            drain();
        end
        $display("test done: every mode and output type");
        slow = 1'b1;
        foreach (rl[i]) begin
            cfg(MODE_DDC4, 1'b0, 4'(rl[i]));
            send(2 * (rl[i] == 0 ? 1 : rl[i]), rl[i] == 0 ? 1 : rl[i]);
            drain();
        end
        $display("test done: decimation ratios");
        for (int i = 0; i < 6; i++) begin
            v = REG_W'($random(seed));
            slow = v[7];
            cfg(v[1:0], v[2], {2'b00, v[4:3]} + 4'h1);
            send(3 * (v[4:3] + 1), v[4:3] + 1);
            drain();
        end
        $display("test done: random configurations");
        {hold, slow} = 2'b10;
        cfg(MODE_FULL, 1'b0, 4'h1);
        fork
            send(6, 1);
            begin
                repeat (8) @(negedge clock_i);
                chk("input refused while full", 1'b0, in_ready_o);
                hold = 1'b0;
            end
        join
        drain();
        $display("test done: receiver stall");
        give_verdict();
    end
    // watchdog: the tests need some hundreds of cycles; it fires at 20000
    initial begin
        #(20000 * 20);
        n_fail++;
        give_verdict();
    end
endmodule // virtual_converter_mapper_bench

bind virtual_converter_mapper vc_map_properties #(.SAMPLE_W(SAMPLE_W)) vc_map_properties_inst (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .slot_data_o(slot_data_o),
    .slot_active_o(slot_active_o), .slot_valid_o(slot_valid_o), .slot_ready_i(slot_ready_i),
    .vc_count_o(vc_count_o));
